// ### design/voice_framer_consts.vh
// constants of the voice packet framer
`ifndef VOICE_FRAMER_CONSTS_VH
`define VOICE_FRAMER_CONSTS_VH
// register byte offsets
`define REG_CTRL        8'h00
`define REG_INTERVAL    8'h04
`define REG_MAX_BYTES   8'h08
`define REG_VLAN_TAG    8'h0c
`define REG_TOS         8'h10
`define REG_SRC_IP      8'h14
`define REG_DST_MAC_HI  8'h18
`define REG_DST_MAC_LO  8'h1c
`define REG_SRC_MAC_HI  8'h20
`define REG_SRC_MAC_LO  8'h24
`define REG_STATUS      8'h28
`define REG_DST_IP_BASE 8'h40
// control field positions
`define CTRL_ENABLE     0
`define CTRL_VLAN       1
`define CTRL_LABEL_FMT  2
`define CTRL_ETH_EN     3
`define CTRL_SER_EN     4
`define CTRL_SIG_BIT    5
`define CTRL_RESET      6'h19
// packetizing interval limits and reset, milliseconds
`define INTERVAL_MIN    7'd10
`define INTERVAL_MAX    7'd90
`define INTERVAL_RESET  7'd40
// multiplexed frame size limits and reset, bytes
`define MAX_BYTES_MIN   11'd100
`define MAX_BYTES_MAX   11'd1461
`define MAX_BYTES_RESET 11'd1461
// header sizes, bytes
`define ETH_HDR_LEN     11'd14
`define VLAN_TAG_LEN    11'd4
`define IP_UDP_MUX_LEN  11'd32
`define LABEL_HDR_LEN   11'd5
`define MUX_HDR_LEN     11'd4
`define SUBHDR_LEN      11'd3
`define FCS_LEN         11'd4
`define HDLC_PRE_LEN    11'd3
`define CONN_FRAME_LEN  11'd64
`define UDP_DST_PORT    16'h085e
`define UDP_PORT_BASE   15'd2
// timing
`define CLK_PERIOD_NS   8
`define MS_IN_NS        1000000
`define CONN_PERIOD_MS  60000
`endif

// ### design/voice_bundle_packet_framer.v
// voice bundle packet framer: input fifo and frame assembler with wishbone registers
//
// Summary of operation
// [R01] packetizing interval register, 10 to 90 ms, bounds frame collection time
// [R02] maximum multiplexed frame size register, 100 to 1461 bytes
// [R03] append packets; close frame when interval elapses or byte limit reached
// [R04] each voice packet gets an aal2 subheader; 4-byte mux header starts frame
// [R05] completed frame wrapped in udp, ip and mac headers
// [R06] finished frames go to ethernet link and serial link
// [R07] serial link copy carries 4 bytes of hdlc framing
// [R08] vlan enabled: 4-byte tag with priority and vlan id in mac header
// [R09] vlan enabled: only tagged frames sent and received
// [R10] udp source port is bundle index plus two; destination port 2142
// [R11] udp source port msb is a free signalling bit
// [R12] ip format headers: ethernet 18, ip 20, udp 8, plus 4 with vlan
// [R13] voice packet is 3-byte subheader, 4-byte voice header, payload
// [R14] label format uses 18-byte ethernet plus 5-byte label header
// [R15] connectivity frames of 64 bytes once per minute
// [R16] packets grouped per bundle, each bundle with its own destination ip
// [R17] link back-pressure stalls framing and the voice source
// [R18] twelve bundles supported; packets for other bundles are dropped
// [R19] interval expiry sends a partial frame only if it holds a packet
`timescale 1ns/1ps
`default_nettype none
`include "voice_framer_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// synchronous fifo with registered flags
module voice_fifo #(
  parameter WIDTH = 27,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  reg [AW:0]      cnt_d;
  reg             not_full_q;
  reg             not_empty_q;
  wire            push = in_valid_i & not_full_q;
  wire            pop  = out_ready_i & not_empty_q;

  assign in_ready_o  = not_full_q;
  assign out_valid_o = not_empty_q;
  assign out_data_o  = mem_q[rd_q];

  // occupancy update
  always @* begin
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // pointers and flags
  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_q        <= {AW{1'b0}};
      rd_q        <= {AW{1'b0}};
      cnt_q       <= {(AW+1){1'b0}};
      not_full_q  <= 1'b1;
      not_empty_q <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH - 1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH - 1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      cnt_q       <= cnt_d;
      not_full_q  <= (cnt_d != DEPTH);
      not_empty_q <= (cnt_d != {(AW+1){1'b0}});
    end
  end

  // storage
  always @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// frame assembler top
module voice_bundle_packet_framer #(
  parameter NUM_BUNDLES    = 12,
  parameter FIFO_DEPTH     = 8,
  parameter CYC_PER_MS     = `MS_IN_NS / `CLK_PERIOD_NS,
  parameter CONN_PERIOD_MS = `CONN_PERIOD_MS
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [7:0]  vp_data_i,
  input  wire        vp_last_i,
  input  wire [3:0]  vp_bundle_i,
  input  wire [7:0]  vp_chan_i,
  input  wire [5:0]  vp_len_i,
  input  wire        vp_valid_i,
  output wire        vp_ready_o,
  output reg  [7:0]  tx_data_o,
  output reg         tx_valid_o,
  output reg         tx_last_o,
  output reg         tx_serial_o,
  input  wire        tx_ready_i
);
  localparam S_FILL = 3'b001;
  localparam S_SUB  = 3'b010;
  localparam S_SEND = 3'b100;

  // byte-lane merge of a write into a stored word
  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer i;
    begin
      lane_merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          lane_merge[8*i +: 8] = new_v[8*i +: 8];
        end
      end
    end
  endfunction

  // reflected crc-32 over one byte
  function [31:0] crc_byte;
    input [31:0] crc;
    input [7:0]  d;
    integer i;
    reg [31:0] c;
    begin
      c = crc;
      for (i = 0; i < 8; i = i + 1) begin
        c = (c[0] ^ d[i]) ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
      end
      crc_byte = c;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // registers
  reg  [5:0]  ctrl_q;
  reg  [6:0]  interval_q;
  reg  [10:0] max_bytes_q;
  reg  [15:0] tci_q;
  reg  [7:0]  tos_q;
  reg  [31:0] src_ip_q;
  reg  [47:0] dmac_q;
  reg  [47:0] smac_q;
  reg  [31:0] dst_ip_q [0:NUM_BUNDLES-1];
  reg  [15:0] frames_q;
  reg  [2:0]  state_q;
  wire        req = wb_cyc_i & wb_stb_i;
  wire        wr  = req & wb_we_i & wb_ack_o;
  wire [5:0]  bidx = wb_adr_i[7:2] - 6'h10;
  reg  [31:0] rd_d;
  wire [31:0] wv  = lane_merge(rd_d, wb_dat_i, wb_sel_i);

  // read mux; unmapped offsets read as zero
  always @* begin
    rd_d = 32'h0;
    case (wb_adr_i)
      `REG_CTRL:       rd_d = {26'h0, ctrl_q};
      `REG_INTERVAL:   rd_d = {25'h0, interval_q};
      `REG_MAX_BYTES:  rd_d = {21'h0, max_bytes_q};
      `REG_VLAN_TAG:   rd_d = {16'h0, tci_q};
      `REG_TOS:        rd_d = {24'h0, tos_q};
      `REG_SRC_IP:     rd_d = src_ip_q;
      `REG_DST_MAC_HI: rd_d = {16'h0, dmac_q[47:32]};
      `REG_DST_MAC_LO: rd_d = dmac_q[31:0];
      `REG_SRC_MAC_HI: rd_d = {16'h0, smac_q[47:32]};
      `REG_SRC_MAC_LO: rd_d = smac_q[31:0];
      `REG_STATUS:     rd_d = {13'h0, state_q, frames_q};
      default: begin
        if (wb_adr_i >= `REG_DST_IP_BASE && bidx < NUM_BUNDLES) begin
          rd_d = dst_ip_q[bidx[3:0]];
        end
      end
    endcase
  end

  // wishbone slave: ack one cycle after the strobe, write at the acked edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h0;
      ctrl_q      <= `CTRL_RESET;
      interval_q  <= `INTERVAL_RESET;
      max_bytes_q <= `MAX_BYTES_RESET;
      tci_q       <= 16'h0;
      tos_q       <= 8'h0;
      src_ip_q    <= 32'h0;
      dmac_q      <= 48'h0;
      smac_q      <= 48'h0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= rd_d;
      if (wr) begin
        case (wb_adr_i)
          `REG_CTRL: ctrl_q <= wv[5:0];
          `REG_INTERVAL: if (wb_sel_i[0]) begin
            interval_q <= (wv[6:0] < `INTERVAL_MIN) ? `INTERVAL_MIN :    // R01
                          (wv[6:0] > `INTERVAL_MAX) ? `INTERVAL_MAX : wv[6:0];
          end
          `REG_MAX_BYTES: if (wb_sel_i[1:0] == 2'b11) begin
            max_bytes_q <= (wv[10:0] < `MAX_BYTES_MIN) ? `MAX_BYTES_MIN : // R02
                           (wv[10:0] > `MAX_BYTES_MAX) ? `MAX_BYTES_MAX : wv[10:0];
          end
          `REG_VLAN_TAG: tci_q <= wv[15:0];
          `REG_TOS: if (wb_sel_i[0]) tos_q <= wb_dat_i[7:0];
          `REG_SRC_IP: src_ip_q <= wv;
          `REG_DST_MAC_HI: dmac_q[47:32] <= wv[15:0];
          `REG_DST_MAC_LO: dmac_q[31:0] <= wv;
          `REG_SRC_MAC_HI: smac_q[47:32] <= wv[15:0];
          `REG_SRC_MAC_LO: smac_q[31:0] <= wv;
          default: ;
        endcase
      end
    end
  end

  // per-bundle destination ip table
  genvar g;
  generate
    for (g = 0; g < NUM_BUNDLES; g = g + 1) begin : ip_tab
      always @(posedge clk_i) begin
        if (rst_i) begin
          dst_ip_q[g] <= 32'h0;
        end else if (wr && wb_adr_i >= `REG_DST_IP_BASE && bidx == g) begin
          dst_ip_q[g] <= wv;  // R16
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // input fifo: the voice source stalls once all FIFO_DEPTH entries fill, as they do while a frame is on the link
  wire [26:0] head;
  wire        head_v;
  reg         pop;
  voice_fifo #(.WIDTH(27), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_data_i   ({vp_bundle_i, vp_chan_i, vp_len_i, vp_last_i, vp_data_i}),
    .in_valid_i  (vp_valid_i),
    .in_ready_o  (vp_ready_o),
    .out_data_o  (head),
    .out_valid_o (head_v),
    .out_ready_i (pop)
  );
  wire [3:0] h_bundle = head[26:23];
  wire [7:0] h_chan   = head[22:15];
  wire [5:0] h_len    = head[14:9];
  wire       h_last   = head[8];
  wire [7:0] h_data   = head[7:0];

  //////////////////////////////////////////////////////////////////////////////
  // millisecond timers
  reg [16:0] tick_q;
  reg [6:0]  ms_q;
  reg [15:0] conn_ms_q;
  reg        conn_pend_q;
  reg        open_q;
  wire       tick = (tick_q == CYC_PER_MS - 1);

  //////////////////////////////////////////////////////////////////////////////
  // frame assembly state
  reg  [7:0]  buf_q [0:2047];
  reg  [10:0] fill_q;
  reg  [3:0]  bundle_q;
  reg         pkt_in_q;
  reg         drop_q;
  reg  [1:0]  sub_q;
  reg  [15:0] seq_q;
  reg         conn_q;
  reg         ser_q;
  reg  [10:0] pos_q;
  reg  [10:0] pl_q;
  reg  [31:0] crc_q;
  wire        vlan  = ctrl_q[`CTRL_VLAN];
  wire        lbl   = ctrl_q[`CTRL_LABEL_FMT];
  wire        adv   = ~tx_valid_o | tx_ready_i;                           // R17
  wire        link  = ctrl_q[`CTRL_ETH_EN] | ctrl_q[`CTRL_SER_EN];        // no link: frame dropped
  wire [10:0] mux_n = lbl ? 11'd0 : `MUX_HDR_LEN;
  wire [10:0] need  = mux_n + fill_q + `SUBHDR_LEN + {5'h0, h_len};
  wire        full_hit = (need > max_bytes_q);                            // R03
  wire        timed    = open_q & (ms_q >= interval_q);                   // R03
  // subheader: channel id, length indicator, zero uui and hec
  wire [23:0] subhdr = {h_chan, h_len - 6'd1, 10'h0};                    // R13

  // header fields
  wire [14:0] port_lo = {11'h0, bundle_q} + `UDP_PORT_BASE;               // R10
  wire [15:0] sport   = {ctrl_q[`CTRL_SIG_BIT], port_lo};                 // R11
  wire [15:0] ip_len  = {5'h0, pl_q + 11'd32};
  wire [15:0] udp_len = {5'h0, pl_q + 11'd12};
  wire [31:0] dip     = dst_ip_q[bundle_q];                               // R16
  wire [19:0] cs_sum  = {4'h0, 8'h45, tos_q} + {4'h0, ip_len} + 20'h04011 +
                        {4'h0, src_ip_q[31:16]} + {4'h0, src_ip_q[15:0]} +
                        {4'h0, dip[31:16]} + {4'h0, dip[15:0]};
  wire [16:0] cs_f1   = {1'b0, cs_sum[15:0]} + {13'h0, cs_sum[19:16]};
  wire [15:0] cs      = ~(cs_f1[15:0] + {15'h0, cs_f1[16]});
  wire [399:0] hdr_ip = {dmac_q, smac_q, 16'h8100, tci_q, 16'h0800,       // R05 R08
                         8'h45, tos_q, ip_len, 32'h0, 16'h4011, cs, src_ip_q, dip,
                         sport, `UDP_DST_PORT, udp_len, 16'h0,            // R10
                         16'h0, seq_q};                                   // R04
  wire [399:0] hdr_lb = {dmac_q, smac_q, 16'h8100, tci_q, 16'h8847,       // R14
                         4'h0, sport, tci_q[15:13], 1'b1, 8'h40, 8'h00, 216'h0};

  // pass segment boundaries: hdlc prefix, header, payload, fcs, hdlc flag
  wire [10:0] pre_n = ser_q ? `HDLC_PRE_LEN : 11'd0;                      // R07
  wire [10:0] hl    = (vlan ? `ETH_HDR_LEN + `VLAN_TAG_LEN : `ETH_HDR_LEN) + // R12
                      (lbl ? `LABEL_HDR_LEN : `IP_UDP_MUX_LEN);
  wire [10:0] e1    = pre_n + hl;
  wire [10:0] e2    = e1 + pl_q;
  wire [10:0] e3    = e2 + `FCS_LEN;
  wire [10:0] tot   = e3 + {10'h0, ser_q};
  wire [10:0] hk    = pos_q - pre_n;
  wire [10:0] hj    = (~vlan && hk >= 11'd12) ? hk + `VLAN_TAG_LEN : hk;  // R09
  wire [399:0] hsh  = (lbl ? hdr_lb : hdr_ip) << {hj, 3'b000};
  wire [10:0] pk    = pos_q - e1;
  wire [31:0] fsh   = ~crc_q >> {pos_q - e2, 3'b000};
  reg  [7:0]  byte_d;

  // byte for the current pass position
  always @* begin
    if (pos_q < pre_n) begin
      byte_d = (pos_q == 11'd0) ? 8'h7e : (pos_q == 11'd1) ? 8'hff : 8'h03;
    end else if (pos_q < e1) begin
      byte_d = hsh[399:392];
    end else if (pos_q < e2) begin
      byte_d = conn_q ? 8'h00 : buf_q[pk];
    end else if (pos_q < e3) begin
      byte_d = fsh[7:0];
    end else begin
      byte_d = 8'h7e;
    end
  end

  // payload store
  always @(posedge clk_i) begin
    if (state_q == S_SUB) begin
      buf_q[fill_q] <= subhdr[8*(2-sub_q) +: 8];                         // R04
    end else if (pop && pkt_in_q && !drop_q) begin
      buf_q[fill_q] <= h_data;
    end
  end

  // fifo pop: payload bytes of an open packet, or bytes of a dropped one
  always @* begin
    pop = (state_q == S_FILL) && head_v && (pkt_in_q || (drop_q && !timed));
  end

  // timers: interval from frame open, connectivity period
  always @(posedge clk_i) begin
    if (rst_i) begin
      tick_q      <= 17'h0;
      ms_q        <= 7'h0;
      conn_ms_q   <= 16'h0;
      conn_pend_q <= 1'b0;
    end else begin
      tick_q <= tick ? 17'h0 : tick_q + 17'h1;
      if (!open_q) begin
        ms_q <= 7'h0;
      end else if (tick && ms_q != 7'h7f) begin
        ms_q <= ms_q + 7'h1;
      end
      if (tick) begin
        conn_ms_q <= (conn_ms_q == CONN_PERIOD_MS - 1) ? 16'h0 : conn_ms_q + 16'h1;
      end
      if (tick && conn_ms_q == CONN_PERIOD_MS - 1 && ctrl_q[`CTRL_ENABLE]) begin
        conn_pend_q <= 1'b1;                                              // R15
      end else if (state_q == S_SEND && conn_q && pos_q == 11'd0) begin
        conn_pend_q <= 1'b0;
      end
    end
  end

  // framing sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q     <= S_FILL;
      fill_q      <= 11'h0;
      bundle_q    <= 4'h0;
      open_q      <= 1'b0;
      pkt_in_q    <= 1'b0;
      drop_q      <= 1'b0;
      sub_q       <= 2'h0;
      seq_q       <= 16'h0;
      frames_q    <= 16'h0;
      conn_q      <= 1'b0;
      ser_q       <= 1'b0;
      pos_q       <= 11'h0;
      pl_q        <= 11'h0;
      crc_q       <= 32'hffffffff;
      tx_data_o   <= 8'h0;
      tx_valid_o  <= 1'b0;
      tx_last_o   <= 1'b0;
      tx_serial_o <= 1'b0;
    end else begin
      case (state_q)
        S_FILL: begin
          if (timed && !pkt_in_q) begin
            state_q <= S_SEND;                                            // R19
            pl_q    <= fill_q;
          end else if (pop) begin
            if (!drop_q) begin
              fill_q <= fill_q + 11'd1;
            end
            if (h_last) begin
              pkt_in_q <= 1'b0;
              drop_q   <= 1'b0;
            end
            if (!drop_q && h_last && mux_n + fill_q + 11'd1 >= max_bytes_q) begin
              state_q <= S_SEND;                                          // R03
              pl_q    <= fill_q + 11'd1;
            end
          end else if (head_v && !pkt_in_q && !drop_q) begin
            if (h_bundle >= NUM_BUNDLES || !ctrl_q[`CTRL_ENABLE]) begin
              drop_q <= 1'b1;                                             // R18
            end else if (open_q && (h_bundle != bundle_q || full_hit)) begin
              state_q <= S_SEND;                                          // R03 R16
              pl_q    <= fill_q;
            end else begin
              state_q  <= S_SUB;
              sub_q    <= 2'h0;
              bundle_q <= h_bundle;
              open_q   <= 1'b1;
            end
          end else if (!open_q && !pkt_in_q && conn_pend_q) begin
            state_q <= S_SEND;                                            // R15
            conn_q  <= 1'b1;
            bundle_q <= 4'h0;
            pl_q    <= `CONN_FRAME_LEN - hl - `FCS_LEN;
          end
          pos_q <= 11'h0;
          ser_q <= ~ctrl_q[`CTRL_ETH_EN];
          crc_q <= 32'hffffffff;
        end
        S_SUB: begin
          fill_q <= fill_q + 11'd1;
          sub_q  <= sub_q + 2'h1;
          if (sub_q == 2'h2) begin
            state_q  <= S_FILL;
            pkt_in_q <= 1'b1;
          end
        end
        S_SEND: begin
          if (adv && pos_q < tot && link) begin
            tx_data_o   <= byte_d;                                        // R06
            tx_valid_o  <= 1'b1;
            tx_last_o   <= (pos_q == tot - 11'd1);
            tx_serial_o <= ser_q;
            pos_q       <= pos_q + 11'd1;
            if (pos_q >= pre_n && pos_q < e2) begin
              crc_q <= crc_byte(crc_q, byte_d);
            end
          end else if (adv) begin
            tx_valid_o <= 1'b0;
            tx_last_o  <= 1'b0;
            if (!ser_q && ctrl_q[`CTRL_SER_EN]) begin
              ser_q <= 1'b1;                                              // R06 R07
              pos_q <= 11'h0;
              crc_q <= 32'hffffffff;
            end else begin
              state_q  <= S_FILL;
              fill_q   <= 11'h0;
              open_q   <= 1'b0;
              conn_q   <= 1'b0;
              seq_q    <= seq_q + 16'h1;
              frames_q <= frames_q + 16'h1;
            end
          end
        end
        default: state_q <= S_FILL;
      endcase
    end
  end
endmodule

`default_nettype wire

// ### verification/voice_framer_assertions.sv
// assertions on the framer's bus and frame output
`timescale 1ns/1ps
`default_nettype none
module voice_framer_checker (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       vp_ready_o,
  input wire logic [7:0] tx_data_o,
  input wire logic       tx_valid_o,
  input wire logic       tx_last_o,
  input wire logic       tx_serial_o,
  input wire logic       tx_ready_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [10:0] pos_q;
  wire         step = tx_valid_o && tx_ready_i;
  // byte position inside the frame on the wire
  always_ff @(posedge clk_i)
    if (rst_i || (step && tx_last_o)) pos_q <= 11'h0;
    else if (step) pos_q <= pos_q + 11'h1;
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_drop; wb_ack_o |=> !wb_ack_o; endproperty
  a_drop: assert property (p_drop) else $error("long ack");
  property p_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  a_idle: assert property (p_idle) else $error("stray ack");
  property p_rst; $past(rst_i) |-> vp_ready_o && !tx_valid_o; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable({tx_data_o, tx_last_o}); endproperty
  a_hold: assert property (p_hold) else $error("byte not held");
  property p_head; tx_valid_o && tx_serial_o && pos_q < 11'h3 |->
    tx_data_o == (pos_q == 11'h0 ? 8'h7e : pos_q == 11'h1 ? 8'hff : 8'h03); endproperty
  a_head: assert property (p_head) else $error("bad serial head");
  property p_tail; tx_valid_o && tx_serial_o && tx_last_o |-> tx_data_o == 8'h7e; endproperty
  a_tail: assert property (p_tail) else $error("bad serial tail");
  property p_type; tx_valid_o && pos_q == (tx_serial_o ? 11'hf : 11'hc) |->
    tx_data_o inside {8'h08, 8'h81, 8'h88}; endproperty
  a_type: assert property (p_type) else $error("bad ethertype");
endmodule
bind voice_bundle_packet_framer voice_framer_checker chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .vp_ready_o(vp_ready_o),
  .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o),
  .tx_serial_o(tx_serial_o), .tx_ready_i(tx_ready_i));
`default_nettype wire

// ### verification/voice_link_sink.sv
// sink standing for the switch behind the framer
`timescale 1ns/1ps
`default_nettype none
module voice_link_sink (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  input  wire logic       tx_last_i,
  input  wire logic       tx_serial_i,
  input  wire logic       slow_i,
  output logic            ready_o
);
  logic [7:0] mem [0:2047];
  logic [1:0] ph_q = 2'h0;
  int         pos, eth_len, ser_len, eth_cnt, ser_cnt;
  // slow mode takes one byte in three
  assign ready_o = !slow_i || ph_q == 2'h0;
  // store the ethernet copy, count both copies
  always @(posedge clk_i) begin
    ph_q <= ph_q == 2'h2 ? 2'h0 : ph_q + 2'h1;
    if (rst_i) begin
      pos = 0;
      eth_cnt = 0;
      ser_cnt = 0;
    end else if (tx_valid_i && ready_o) begin
      if (!tx_serial_i) mem[pos] = tx_data_i;
      pos++;
      if (tx_last_i && tx_serial_i) begin
        ser_len = pos;
        ser_cnt++;
      end
      if (tx_last_i && !tx_serial_i) begin
        eth_len = pos;
        eth_cnt++;
      end
      if (tx_last_i) pos = 0;
    end
  end
endmodule
`default_nettype wire

// ### verification/voice_bundle_packet_framer_bench.sv
// self-checking bench of the voice bundle packet framer
`timescale 1ns/1ps
`default_nettype none
`include "voice_framer_consts.vh"
module voice_bundle_packet_framer_bench;
  logic        clk_i = 1'b0, rst_i = 1'b1, slow = 1'b0, wb_ack_o, vp_ready_o;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, vp_last_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00, vp_data_i = 8'h00, vp_chan_i = 8'h00, tx_data_o;
  logic [3:0]  wb_sel_i = 4'hf, vp_bundle_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [5:0]  vp_len_i = 6'h01;
  logic        vp_valid_i = 1'b0, tx_valid_o, tx_last_o, tx_serial_o, tx_ready_i;
  int          err_total = 0, samples_checked = 0, base;
  always #4 clk_i = ~clk_i;
  voice_bundle_packet_framer #(.CYC_PER_MS(20), .CONN_PERIOD_MS(500)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .vp_data_i(vp_data_i), .vp_last_i(vp_last_i),
    .vp_bundle_i(vp_bundle_i), .vp_chan_i(vp_chan_i), .vp_len_i(vp_len_i),
    .vp_valid_i(vp_valid_i), .vp_ready_o(vp_ready_o), .tx_data_o(tx_data_o),
    .tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o), .tx_serial_o(tx_serial_o),
    .tx_ready_i(tx_ready_i));
  voice_link_sink sink (.clk_i(clk_i), .rst_i(rst_i), .tx_data_i(tx_data_o),
    .tx_valid_i(tx_valid_o), .tx_last_i(tx_last_o), .tx_serial_i(tx_serial_o),
    .slow_i(slow), .ready_o(tx_ready_i));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic give_up;
    err_total++;
    wrap_up();
  endtask
  // one classic wishbone cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 50);
    if (i >= 50) give_up();
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic [31:0] q;
    wb(1'b1, a, d, s, q);
  endtask
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hf, q);
    check(what, q, exp);
  endtask
  // one voice packet, bytes 64, 65, ... held until taken
  task automatic pkt(input logic [3:0] b, input logic [7:0] c, input logic [5:0] len);
    int t;
    for (int i = 0; i < len; i++) begin
      vp_valid_i  <= 1'b1;
      vp_bundle_i <= b;
      vp_chan_i   <= c;
      vp_len_i    <= len;
      vp_data_i   <= 8'(i + 64);
      vp_last_i   <= (i == len - 1);
      t = 0;
      do begin
        @(posedge clk_i);
        t++;
      end while (vp_ready_o !== 1'b1 && t < 5000);
      if (t >= 5000) give_up();
    end
    vp_valid_i <= 1'b0;
    vp_last_i  <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_for(input int k);
    for (int t = 0; sink.ser_cnt < k; t++) begin
      if (t >= 4000) give_up();
      @(posedge clk_i);
    end
  endtask
  function automatic logic [31:0] fld(input int p, input int n);
    fld = 32'h0;
    for (int k = 0; k < n; k++) fld = {fld[23:0], sink.mem[p + k]};
  endfunction
  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd("ctrl", `REG_CTRL, 32'h19);
    rd("maxb", `REG_MAX_BYTES, 32'h5b5);
    rd("hole", 8'h3c, 32'h0);
    wr(`REG_INTERVAL, 32'h5f);
    wr(`REG_INTERVAL, 32'h20, 4'he);
    rd("ival", `REG_INTERVAL, 32'h5a);
    wr(`REG_MAX_BYTES, 32'h32);
    rd("maxb", `REG_MAX_BYTES, 32'h64);
    wr(`REG_MAX_BYTES, 32'h7d0);
    wr(`REG_INTERVAL, 32'h5);
    wr(`REG_CTRL, 32'h39);
    wr(`REG_DST_IP_BASE + 8'h10, 32'h0a000105);
    base = sink.ser_cnt;
    pkt(4'h4, 8'h21, 6'h07);
    wait_for(base + 1);
    check("eth len", 32'(sink.eth_len), 32'h3c);
    check("ser len", 32'(sink.ser_len), 32'h40);
    check("type", fld(12, 2), 32'h0800);
    check("dst ip", fld(30, 4), 32'h0a000105);
    check("sport", fld(34, 2), 32'h8006);
    check("dport", fld(36, 2), 32'h085e);
    check("mux", fld(42, 2), 32'h0);
    check("sub", fld(46, 4), 32'h21180040);
    base = sink.eth_cnt;
    pkt(4'hc, 8'h21, 6'h07);
    repeat (600) @(posedge clk_i);
    check("drop", 32'(sink.eth_cnt), 32'(base));
    wr(`REG_MAX_BYTES, 32'h64);
    wr(`REG_INTERVAL, 32'h5a);
    slow <= 1'b1;
    base = sink.ser_cnt;
    repeat (3) pkt(4'h1, 8'h02, 6'h1e);
    wait_for(base + 1);
    check("limit", 32'(sink.eth_len), 32'h74);
    wait_for(base + 2);
    check("late", 32'(sink.eth_len), 32'h53);
    slow <= 1'b0;
    wr(`REG_INTERVAL, 32'ha);
    wr(`REG_VLAN_TAG, 32'ha005);
    wr(`REG_CTRL, 32'h1b);
    base = sink.ser_cnt;
    pkt(4'h0, 8'h33, 6'h07);
    wait_for(base + 1);
    check("tag", fld(12, 4), 32'h8100a005);
    wr(`REG_CTRL, 32'h1d);
    pkt(4'h0, 8'h33, 6'h07);
    wait_for(base + 2);
    check("label", fld(12, 2), 32'h8847);
    check("lab len", 32'(sink.eth_len), 32'h21);
    base = sink.eth_cnt;
    for (int t = 0; t < 12000 && sink.eth_cnt == base; t++) @(posedge clk_i);
    check("conn len", 32'(sink.eth_len), 32'h40);
    wrap_up();
  end
endmodule
`default_nettype wire
